// file: rtl/sdc_control.sv
// converter control: settings, modulator clock, decimation, calibration
// Functional notes
// - runs only when enabled; else clocks stopped
// - shutdown keeps settings, mode forced idle
// - reference select 1 external, 0 internal
// - gain field picks 1 to 128
// - buffers per input: low, high, bypass
// - divided modulator clock, sample every 128
// - decimation ratio is one plus field
// - word rate is samples over ratio
// - offset calibration stores, then subtracted
// - gain calibration uses offset as second point
// - corrected result multiplied by gain factor
// - mode write starts calibration; busy held
// - completion: idle, busy clear, flags, coefficients
// - clearing interrupt flag clears complete flag
// - internal or system offset, gain, or full sequence
// - internal offset grounds both inputs
// - internal gain applies reference over gain
// - offset coefficient 24-bit, three byte registers
// - gain coefficient 24-bit fraction, three bytes
`timescale 1ns/1ps
module sdc_control
    import sdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic mod_sample_valid,
    input wire logic signed [23:0] mod_sample,
    output logic modulator_clock,
    output logic modulator_enable,
    output logic reference_select,
    output logic [2:0] amplifier_gain_field,
    output logic [1:0] positive_buffer_sel,
    output logic [1:0] negative_buffer_sel,
    output logic [1:0] input_source,
    output logic signed [23:0] result_word,
    output logic result_valid,
    output logic converter_interrupt
);
    logic [7:0] mode_reg, mode_next, ctrl_reg, ctrl_next, buf_reg, buf_next;
    logic [7:0] div_reg, div_next;
    logic [10:0] decimation_field_reg, decimation_field_next;
    logic [23:0] off_reg, off_next, gain_reg, gain_next;
    logic int_reg, int_next, calc_reg, calc_next;
    sdc_cal_t cal_reg, cal_next;
    logic gain_pend_reg, gain_pend_next;
    logic [7:0] divcnt_reg, divcnt_next;
    logic mclk_reg, mclk_next;
    logic [6:0] mcnt_reg, mcnt_next;
    logic [10:0] dcnt_reg, dcnt_next;
    logic signed [31:0] acc_reg, acc_next;
    logic signed [23:0] res_reg, res_next;
    logic rv_reg, rv_next;
    logic [7:0] rdata_reg, rdata_next;
    logic enabled, wr_mode, sample_tick, word_done, busy;
    logic signed [31:0] acc_sum;
    logic signed [23:0] raw_word, corr;
    logic signed [48:0] prod;
    logic [2:0] sm;
    logic [23:0] gain_calc;

    assign enabled = mode_reg[MODE_EN_BIT];
    assign sm = mode_reg[MODE_SM_LSB +: 3];
    assign busy = (cal_reg != CS_IDLE);
    assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
    assign sample_tick = enabled && mod_sample_valid;
    assign acc_sum = acc_reg + 32'(mod_sample);
    assign word_done = sample_tick && (dcnt_reg == decimation_field_reg);
    // average keeps scale; the 32-bit sum stays in range because software holds the ratio
    // at or below 256
    assign raw_word = 24'(acc_sum / $signed({21'h0, decimation_field_reg} + 32'sd1));
    assign corr = raw_word - $signed(off_reg);
    assign prod = corr * $signed({1'b0, gain_reg});
    // two-point slope: full scale over (measured minus offset)
    always_comb begin
        logic signed [24:0] span;
        logic [47:0] quot;
        span = 25'(raw_word) - 25'($signed(off_reg));
        quot = 48'h0;
        if (span <= 25'sd0) begin
            gain_calc = 24'hffffff;
        end else begin
            quot = (48'h7fffff << 23) / 48'(span);
            // slopes past the register's top clip rather than wrap
            gain_calc = (quot > 48'hffffff) ? 24'hffffff : quot[23:0];
        end
    end

    always_comb begin
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        buf_next = buf_reg;
        div_next = div_reg;
        decimation_field_next = decimation_field_reg;
        off_next = off_reg;
        gain_next = gain_reg;
        int_next = int_reg;
        calc_next = calc_reg;
        cal_next = cal_reg;
        gain_pend_next = gain_pend_reg;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MODE: mode_next = reg_wdata;
                ADDR_CTRL: ctrl_next = reg_wdata;
                ADDR_BUF: buf_next = reg_wdata;
                ADDR_CLKDIV: div_next = reg_wdata;
                ADDR_DECH: decimation_field_next[10:8] = reg_wdata[2:0];
                ADDR_DECL: decimation_field_next[7:0] = reg_wdata;
                ADDR_OFFH: off_next[23:16] = reg_wdata;
                ADDR_OFFM: off_next[15:8] = reg_wdata;
                ADDR_OFFL: off_next[7:0] = reg_wdata;
                ADDR_GAINH: gain_next[23:16] = reg_wdata;
                ADDR_GAINM: gain_next[15:8] = reg_wdata;
                ADDR_GAINL: gain_next[7:0] = reg_wdata;
                ADDR_STAT: begin
                    if (!reg_wdata[STAT_INT_BIT]) begin
                        int_next = 1'b0;
                        calc_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        case (cal_reg)
            CS_IDLE: begin
                // a fresh calibration code starts a sequence
                if (wr_mode && reg_wdata[MODE_EN_BIT]) begin
                    case (reg_wdata[2:0])
                        SM_INT_OFF, SM_INT_GAIN, SM_SYS_OFF, SM_SYS_GAIN:
                            cal_next = CS_MEAS;
                        SM_FULL: begin
                            cal_next = CS_MEAS;
                            gain_pend_next = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            CS_MEAS: begin
                if (word_done) begin
                    cal_next = CS_CALC;
                end
            end
            CS_CALC: cal_next = CS_IDLE;
            default: cal_next = CS_IDLE;
        endcase
        if (cal_reg == CS_MEAS && word_done) begin
            case (sm)
                SM_INT_OFF, SM_SYS_OFF, SM_FULL: begin
                    off_next = raw_word;
                end
                default: gain_next = gain_calc;
            endcase
            if (sm == SM_FULL) begin
                // offset step done; the gain step follows on its own
                mode_next[2:0] = SM_INT_GAIN;
                gain_pend_next = 1'b0;
                cal_next = CS_MEAS;
            end else begin
                mode_next[2:0] = SM_IDLE;
                // busy drops in the same cycle the flags rise
                cal_next = CS_IDLE;
                int_next = 1'b1;
                calc_next = 1'b1;
            end
        end
        if (!mode_next[MODE_EN_BIT]) begin
            mode_next[2:0] = SM_IDLE;
            cal_next = CS_IDLE;
            gain_pend_next = 1'b0;
        end
    end

    // modulator clock divider; halted in shutdown to save power
    always_comb begin
        divcnt_next = divcnt_reg;
        mclk_next = mclk_reg;
        mcnt_next = mcnt_reg;
        if (!enabled) begin
            divcnt_next = 8'h00;
            mclk_next = 1'b0;
            mcnt_next = 7'h00;
        end else if (divcnt_reg >= div_reg) begin
            divcnt_next = 8'h00;
            mclk_next = !mclk_reg;
            if (mclk_reg) begin
                // counts modulator clocks; a sample falls each wrap
                if (mcnt_reg == MOD_CLKS_PER_SAMPLE_M1) begin
                    mcnt_next = 7'h00;
                end else begin
                    mcnt_next = mcnt_reg + 7'h01;
                end
            end
        end else begin
            divcnt_next = divcnt_reg + 8'h01;
        end
    end

    always_comb begin
        dcnt_next = dcnt_reg;
        acc_next = acc_reg;
        res_next = res_reg;
        rv_next = 1'b0;
        if (!enabled || (wr_mode && cal_reg == CS_IDLE)) begin
            dcnt_next = 11'h000;
            acc_next = 32'sd0;
        end else if (sample_tick) begin
            if (word_done) begin
                dcnt_next = 11'h000;
                acc_next = 32'sd0;
                if (cal_reg == CS_IDLE) begin
                    res_next = 24'(prod >>> 23);
                    rv_next = 1'b1;
                end
            end else begin
                dcnt_next = dcnt_reg + 11'h001;
                acc_next = acc_sum;
            end
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE: rdata_next = mode_reg;
                ADDR_CTRL: rdata_next = ctrl_reg;
                ADDR_BUF: rdata_next = buf_reg;
                ADDR_CLKDIV: rdata_next = div_reg;
                ADDR_DECH: rdata_next = {5'h00, decimation_field_reg[10:8]};
                ADDR_DECL: rdata_next = decimation_field_reg[7:0];
                ADDR_OFFH: rdata_next = off_reg[23:16];
                ADDR_OFFM: rdata_next = off_reg[15:8];
                ADDR_OFFL: rdata_next = off_reg[7:0];
                ADDR_GAINH: rdata_next = gain_reg[23:16];
                ADDR_GAINM: rdata_next = gain_reg[15:8];
                ADDR_GAINL: rdata_next = gain_reg[7:0];
                ADDR_STAT: rdata_next = {5'h00, busy, calc_reg, int_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_RST;
            ctrl_reg <= CTRL_RST;
            buf_reg <= BUF_RST;
            div_reg <= CLKDIV_RST;
            decimation_field_reg <= DECIMATION_FIELD_RST;
            off_reg <= OFF_RST;
            gain_reg <= GAIN_RST;
            int_reg <= 1'b0;
            calc_reg <= 1'b0;
            cal_reg <= CS_IDLE;
            gain_pend_reg <= 1'b0;
            divcnt_reg <= 8'h00;
            mclk_reg <= 1'b0;
            mcnt_reg <= 7'h00;
            dcnt_reg <= 11'h000;
            acc_reg <= 32'sd0;
            res_reg <= 24'sd0;
            rv_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            buf_reg <= buf_next;
            div_reg <= div_next;
            decimation_field_reg <= decimation_field_next;
            off_reg <= off_next;
            gain_reg <= gain_next;
            int_reg <= int_next;
            calc_reg <= calc_next;
            cal_reg <= cal_next;
            gain_pend_reg <= gain_pend_next;
            divcnt_reg <= divcnt_next;
            mclk_reg <= mclk_next;
            mcnt_reg <= mcnt_next;
            dcnt_reg <= dcnt_next;
            acc_reg <= acc_next;
            res_reg <= res_next;
            rv_reg <= rv_next;
            rdata_reg <= rdata_next;
        end
    end

    always_comb begin
        input_source = SRC_PINS;
        if (busy && sm == SM_FULL) begin
            input_source = SRC_GROUND;
        end else if (busy && sm == SM_INT_OFF) begin
            input_source = SRC_GROUND;
        end else if (busy && sm == SM_INT_GAIN) begin
            input_source = SRC_FULLSCALE;
        end
    end

    assign reg_rdata = rdata_reg;
    assign modulator_clock = mclk_reg;
    assign modulator_enable = enabled;
    assign reference_select = ctrl_reg[CTRL_VREF_BIT];
    assign amplifier_gain_field = ctrl_reg[CTRL_GAIN_LSB +: 3];
    assign positive_buffer_sel = buf_reg[1:0];
    assign negative_buffer_sel = buf_reg[3:2];
    assign result_word = res_reg;
    assign result_valid = rv_reg;
    assign converter_interrupt = int_reg;
endmodule // sdc_control

// file: rtl/sdc_pkg.sv
// package: register map, field layout and constants of the converter control
package sdc_pkg;
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_BUF = 4'h2;
    localparam logic [3:0] ADDR_CLKDIV = 4'h3;
    localparam logic [3:0] ADDR_DECH = 4'h4;
    localparam logic [3:0] ADDR_DECL = 4'h5;
    localparam logic [3:0] ADDR_OFFH = 4'h6;
    localparam logic [3:0] ADDR_OFFM = 4'h7;
    localparam logic [3:0] ADDR_OFFL = 4'h8;
    localparam logic [3:0] ADDR_GAINH = 4'h9;
    localparam logic [3:0] ADDR_GAINM = 4'ha;
    localparam logic [3:0] ADDR_GAINL = 4'hb;
    localparam logic [3:0] ADDR_STAT = 4'hc;
    // mode register fields
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_SM_LSB = 0;
    // control register fields
    localparam int CTRL_VREF_BIT = 4;
    localparam int CTRL_GAIN_LSB = 0;
    // status register fields (write 0 to int bit clears it)
    localparam int STAT_INT_BIT = 0;
    localparam int STAT_CALC_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [7:0] CLKDIV_RST = 8'h00;
    localparam logic [10:0] DECIMATION_FIELD_RST = 11'h7ff;
    localparam logic [23:0] OFF_RST = 24'h000000;
    localparam logic [23:0] GAIN_RST = 24'h800000;
    // sampling: one modulator sample per this many plus one modulator clocks
    localparam logic [6:0] MOD_CLKS_PER_SAMPLE_M1 = 7'h7f;
    // system mode codes
    typedef enum logic [2:0] {
        SM_IDLE = 3'b000,
        SM_CONT = 3'b001,
        SM_INT_OFF = 3'b100,
        SM_INT_GAIN = 3'b101,
        SM_SYS_OFF = 3'b110,
        SM_SYS_GAIN = 3'b111,
        SM_FULL = 3'b011
    } sdc_mode_t;
    // input source routed to the modulator
    typedef enum logic [1:0] {
        SRC_PINS = 2'b00,
        SRC_GROUND = 2'b01,
        SRC_FULLSCALE = 2'b10
    } sdc_src_t;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_MEAS = 2'b01,
        CS_CALC = 2'b10
    } sdc_cal_t;
endpackage

// file: verification/sdc_control_asserts.sv
// checker: port relations of the converter control
`timescale 1ns/1ps
module sdc_control_asserts
    import sdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic mod_sample_valid,
    input wire logic signed [23:0] mod_sample,
    input wire logic modulator_clock,
    input wire logic modulator_enable,
    input wire logic reference_select,
    input wire logic [2:0] amplifier_gain_field,
    input wire logic [1:0] positive_buffer_sel,
    input wire logic [1:0] negative_buffer_sel,
    input wire logic [1:0] input_source,
    input wire logic signed [23:0] result_word,
    input wire logic result_valid,
    input wire logic converter_interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence mode_wr;
        reg_wr && reg_addr == ADDR_MODE;
    endsequence
    sequence ctrl_wr;
        reg_wr && reg_addr == ADDR_CTRL;
    endsequence
    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_enable_follows: assert property (mode_wr |=>
        modulator_enable == $past(reg_wdata[MODE_EN_BIT]))
        else $error("enable does not follow mode write");
    a_clock_stopped: assert property (!modulator_enable [*2] |->
        !modulator_clock)
        else $error("modulator clock runs while disabled");
    a_ctrl_write: assert property (ctrl_wr |=>
        amplifier_gain_field == $past(reg_wdata[2:0]) &&
        reference_select == $past(reg_wdata[CTRL_VREF_BIT]))
        else $error("gain or reference not taken from write");
    a_ctrl_kept: assert property (!ctrl_wr |=>
        $stable(amplifier_gain_field) && $stable(reference_select))
        else $error("gain or reference changed without write");
    a_buf_write: assert property (reg_wr && reg_addr == ADDR_BUF |=>
        positive_buffer_sel == $past(reg_wdata[1:0]) &&
        negative_buffer_sel == $past(reg_wdata[3:2]))
        else $error("buffer selects not taken from write");
    a_cal_ground: assert property (mode_wr and reg_wdata == 8'h84 |=>
        input_source == SRC_GROUND)
        else $error("offset calibration does not ground inputs");
    a_word_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_word_enabled: assert property (result_valid |->
        $past(modulator_enable))
        else $error("result while disabled");
    a_word_no_cal: assert property (result_valid |->
        input_source == SRC_PINS)
        else $error("result during internal calibration");
endmodule // sdc_control_asserts
bind sdc_control sdc_control_asserts i_sdc_control_asserts (.*);

// file: verification/sdc_control_test.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module sdc_control_test
    import sdc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] pin_level = 24'h000000;
    logic [7:0] reg_rdata;
    logic mod_sample_valid, modulator_clock, modulator_enable;
    logic reference_select, result_valid, converter_interrupt;
    logic signed [23:0] mod_sample, result_word;
    logic [2:0] amplifier_gain_field;
    logic [1:0] positive_buffer_sel, negative_buffer_sel, input_source;
    int miscompares = 0;
    int n_compared = 0;
    int n;
    time t;
    sdc_control i_sdc_control (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mod_sample_valid(mod_sample_valid), .mod_sample(mod_sample),
        .modulator_clock(modulator_clock),
        .modulator_enable(modulator_enable),
        .reference_select(reference_select),
        .amplifier_gain_field(amplifier_gain_field),
        .positive_buffer_sel(positive_buffer_sel),
        .negative_buffer_sel(negative_buffer_sel),
        .input_source(input_source), .result_word(result_word),
        .result_valid(result_valid),
        .converter_interrupt(converter_interrupt));
    sdc_modulator_model i_sdc_modulator_model (.core_clk(core_clk),
        .rst(rst), .modulator_clock(modulator_clock),
        .modulator_enable(modulator_enable), .input_source(input_source),
        .pin_level(pin_level), .mod_sample_valid(mod_sample_valid),
        .mod_sample(mod_sample));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic word(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            #1 c++;
        end while (result_valid !== 1'b1 && c < 12000);
    endtask
    // one calibration run from start to cleared flags
    task automatic cal(input logic [7:0] m, input logic [23:0] p);
        int i;
        pin_level <= p;
        wr(ADDR_MODE, m);
        rd(ADDR_STAT, 8'h04);
        for (i = 0; i < 12000 && converter_interrupt !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(converter_interrupt, 1'b1)
        rd(ADDR_MODE, 8'h80);
        rd(ADDR_STAT, 8'h03);
        wr(ADDR_STAT, 8'h00);
        rd(ADDR_STAT, 8'h00);
    endtask
    task automatic t_reset();
        rd(ADDR_MODE, 8'h00);
        rd(ADDR_DECH, 8'h07);
        rd(ADDR_DECL, 8'hff);
        rd(ADDR_GAINH, 8'h80);
        rd(ADDR_OFFH, 8'h00);
        rd(4'hd, 8'h00);
    endtask
    task automatic t_settings();
        wr(ADDR_CTRL, 8'h17);
        `CHK(reference_select, 1'b1)
        `CHK(amplifier_gain_field, 3'h7)
        wr(ADDR_CTRL, 8'h03);
        `CHK(reference_select, 1'b0)
        wr(ADDR_BUF, 8'h09);
        `CHK({negative_buffer_sel, positive_buffer_sel}, 4'h9)
        wr(ADDR_BUF, 8'h06);
        `CHK({negative_buffer_sel, positive_buffer_sel}, 4'h6)
        wr(ADDR_DECH, 8'h00);
        // no fast filter here, so ratio 20 need not be a multiple of 8
        wr(ADDR_DECL, 8'h13);
        rd(ADDR_DECL, 8'h13);
    endtask
    task automatic t_clock();
        wr(ADDR_CLKDIV, 8'h01);
        wr(ADDR_MODE, 8'h80);
        @(posedge modulator_clock);
        t = $time;
        @(posedge modulator_clock);
        `CHK($time - t, 64'd80)
        wr(ADDR_CLKDIV, 8'h00);
    endtask
    // ratio 20 at 256 core clocks per sample
    task automatic t_convert();
        pin_level <= 24'h000323;
        wr(ADDR_MODE, 8'h81);
        word(n);
        word(n);
        `CHK(n, 5120)
        `CHK(result_word, 24'sh000200)
        wr(ADDR_GAINH, 8'h40);
        word(n);
        word(n);
        `CHK(result_word, 24'sh000100)
        wr(ADDR_GAINH, 8'h80);
        wr(ADDR_STAT, 8'h00);
    endtask
    task automatic t_shutdown();
        wr(ADDR_MODE, 8'h84);
        wr(ADDR_MODE, 8'h04);
        rd(ADDR_MODE, 8'h00);
        rd(ADDR_STAT, 8'h00);
        rd(ADDR_CTRL, 8'h03);
        rd(ADDR_DECL, 8'h13);
        `CHK(modulator_clock, 1'b0)
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(95000 * 20);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_settings();
        t_clock();
        pin_level <= 24'h0ff000;
        cal(8'h84, 24'h0ff000);
        rd(ADDR_OFFM, 8'h01);
        rd(ADDR_OFFL, 8'h23);
        t_convert();
        // offset run above comes before this gain run
        cal(8'h85, 24'h000000);
        rd(ADDR_GAINH, 8'hff);
        cal(8'h83, 24'h000000);
        rd(ADDR_OFFL, 8'h23);
        rd(ADDR_GAINL, 8'hfe);
        cal(8'h86, 24'h000050);
        rd(ADDR_OFFL, 8'h50);
        cal(8'h87, 24'h400050);
        rd(ADDR_GAINM, 8'hff);
        t_shutdown();
        conclude();
    end
endmodule // sdc_control_test

// file: verification/sdc_modulator_model.sv
// modulator and analog front end model feeding samples back
`timescale 1ns/1ps
module sdc_modulator_model
    import sdc_pkg::*;
#(
    parameter logic [23:0] ZERO_ERR = 24'h000123,
    parameter logic [23:0] FULL_SCALE = 24'h400123
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic modulator_clock,
    input wire logic modulator_enable,
    input wire logic [1:0] input_source,
    input wire logic [23:0] pin_level,
    output logic mod_sample_valid,
    output logic signed [23:0] mod_sample
);
    logic mclk_d;
    logic [6:0] edges;
    logic [23:0] level;
    // grounded inputs still show the front end's own offset
    always_comb begin
        case (input_source)
            SRC_GROUND: level = ZERO_ERR;
            SRC_FULLSCALE: level = FULL_SCALE;
            default: level = pin_level;
        endcase
    end
    // one sample per 128 modulator clocks, none while disabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mclk_d <= 1'b0;
            edges <= 7'h00;
            mod_sample_valid <= 1'b0;
            mod_sample <= 24'h000000;
        end else begin
            mclk_d <= modulator_clock;
            mod_sample_valid <= 1'b0;
            mod_sample <= ~mod_sample;
            if (!modulator_enable) begin
                edges <= 7'h00;
            end else if (modulator_clock && !mclk_d) begin
                edges <= edges + 7'h01;
                if (edges == MOD_CLKS_PER_SAMPLE_M1) begin
                    mod_sample_valid <= 1'b1;
                    mod_sample <= level;
                end
            end
        end
    end
endmodule // sdc_modulator_model
